// [logic/csi_tx_interrupt.sv]
// CSI-2 transmit interrupt enables, latched flags and filter range register.
// Assumes the I2C slave delivers byte accesses as one-cycle strobes in reg_req_t.
`default_nettype none
`include "csi_tx_irq_params.svh"

module csi_tx_interrupt
  import csi_tx_irq_pkg::*;
#(
  parameter int NUM_TX_PORTS = 2,  // Transmit ports with own register copies
  parameter int NUM_RX_PORTS = 4   // Receive ports that may forward
) (
  input  wire logic                             sys_clk,          // System clock
  input  wire logic                             resetn,           // Async reset, active low
  input  wire reg_req_t                         regReq,           // Register access strobe
  output logic [7:0]                            regRdata,         // Read data, one cycle later
  input  wire logic [NUM_RX_PORTS-1:0]          rxValid,          // Receive port valid video
  input  wire logic [NUM_RX_PORTS-1:0]          rxIntPending,     // Receive port interrupt pending
  input  wire logic [NUM_TX_PORTS*NUM_RX_PORTS-1:0] forwardMask,  // Enabled ports per transmit port
  input  wire logic                             passAllMode,      // 1: pass needs all enabled ports
  input  wire logic                             syncForwardEn,    // Synchronized forwarding on
  input  wire logic [NUM_TX_PORTS-1:0]          syncedIn,         // Streams synchronized
  input  wire logic [NUM_TX_PORTS-1:0]          syncFaultIn,      // Sync error pulse
  output logic [NUM_TX_PORTS-1:0]               irqOut,           // Interrupt request per port
  output logic [NUM_TX_PORTS-1:0]               passLive,         // Live pass state
  output logic [NUM_TX_PORTS-1:0]               syncedLive,       // Live synchronized state
  output logic [3:0]                            filterUpperBound, // Maximum filter setting
  output logic [3:0]                            filterLowerBound, // Minimum filter setting
  output logic                                  portSelect        // Selected transmit port
);

  // ---------------------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------------------
  logic [7:0]              filterReg, filterNext;
  logic                    portSelReg, portSelNext;
  logic [7:0]              rdataReg, rdataNext;
  logic [NUM_RX_PORTS-1:0] rxValidReg;
  irq_bits_t               enableArr [NUM_TX_PORTS];
  irq_bits_t               flagArr   [NUM_TX_PORTS];
  logic [NUM_TX_PORTS-1:0] passLossHit;
  logic [NUM_TX_PORTS-1:0] passRaw;

  // Decode one register access against an offset
  function automatic logic hit(input reg_req_t r, input logic [7:0] a, input logic isWrite);
    hit = (isWrite ? r.write : r.read) && (r.addr == a);
  endfunction

  // ---------------------------------------------------------------------------
  // Per-port flag banks
  // ---------------------------------------------------------------------------
  for (genvar p = 0; p < NUM_TX_PORTS; p++) begin : g_port
    logic [NUM_RX_PORTS-1:0] mask;
    logic                    selected;
    logic                    anyValid;
    logic                    allValid;
    // Pass mode chooses any or all enabled forwarded ports
    always_comb begin
      mask     = forwardMask[p*NUM_RX_PORTS +: NUM_RX_PORTS];
      selected = (portSelReg == 1'(p));
      anyValid = |(rxValid & mask);
      allValid = (mask != '0) && ((rxValid & mask) == mask);
      passRaw[p]     = passAllMode ? allValid : anyValid;
      passLossHit[p] = |(rxValidReg & ~rxValid & mask);
    end
    tx_port_flags u_flags (
      .sys_clk       (sys_clk),
      .resetn        (resetn),
      .enableWrite   (selected && hit(regReq, `ADDR_IRQ_ENABLE, 1'b1)),
      .writeData     (regReq.wdata[`IRQ_FIELD_W-1:0]),
      .flagsRead     (selected && hit(regReq, `ADDR_IRQ_FLAGS, 1'b0)),
      .rxEventLevel  (|(rxIntPending & mask)),
      .syncFaultHit  (syncFaultIn[p]),
      .passLossHit   (passLossHit[p]),
      .syncedRaw     (syncedIn[p] & syncForwardEn),
      .passRaw       (passRaw[p]),
      .enableReg     (enableArr[p]),
      .flagsReg      (flagArr[p]),
      .irqReg        (irqOut[p]),
      .syncedLiveReg (syncedLive[p]),
      .passLiveReg   (passLive[p])
    );
  end

  // ---------------------------------------------------------------------------
  // Shared registers and read mux
  // ---------------------------------------------------------------------------
  // Reserved bits read as zero; read data captured before the clear lands
  always_comb begin
    filterNext  = hit(regReq, `ADDR_FILTER_RANGE, 1'b1) ? regReq.wdata : filterReg;
    portSelNext = hit(regReq, `ADDR_PORT_SELECT, 1'b1) ? regReq.wdata[`PORT_SELECT_BIT] : portSelReg;
    rdataNext   = rdataReg;
    if (regReq.read) begin
      case (regReq.addr)
        `ADDR_PORT_SELECT:  rdataNext = {7'h00, portSelReg};
        `ADDR_IRQ_ENABLE:   rdataNext = {3'h0, enableArr[portSelReg]};
        `ADDR_IRQ_FLAGS:    rdataNext = {3'h0, flagArr[portSelReg]};
        `ADDR_FILTER_RANGE: rdataNext = filterReg;
        default:            rdataNext = 8'h00;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      filterReg  <= `RESET_FILTER;
      portSelReg <= `RESET_PORT_SELECT;
      rdataReg   <= 8'h00;
      rxValidReg <= '0;
    end else begin
      filterReg  <= filterNext;
      portSelReg <= portSelNext;
      rdataReg   <= rdataNext;
      rxValidReg <= rxValid;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata         = rdataReg;
  assign portSelect       = portSelReg;
  assign filterUpperBound = filterReg[`FILTER_UPPER_LSB +: 4];
  assign filterLowerBound = filterReg[`FILTER_LOWER_LSB +: 4];

  // ---------------------------------------------------------------------------
  // Assertions on transmit port 0 and the shared filter range register
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic flagsRead0;
  assign flagsRead0 = (portSelReg == 1'b0) && hit(regReq, `ADDR_IRQ_FLAGS, 1'b0);

  AST_IRQ_COMBINE: assert property (irqOut[0] == |(flagArr[0] & enableArr[0]))
    else $error("irq does not match flags and enables");
  AST_PASS_LATCH: assert property ($rose(passLive[0]) |-> flagArr[0].passEvent)
    else $error("pass rise not latched");
  AST_SYNC_LATCH: assert property ($rose(syncedLive[0]) |-> flagArr[0].synced)
    else $error("synced rise not latched");
  AST_SYNC_GATED: assert property (!syncForwardEn |=> !syncedLive[0])
    else $error("synced live while sync disabled");
  AST_RX_FOLLOW: assert property (|(rxIntPending & g_port[0].mask) |=> flagArr[0].rxEvent)
    else $error("receive flag not following source");
  AST_FAULT_CLEAR: assert property (flagsRead0 && !syncFaultIn[0] |=> !flagArr[0].syncFault)
    else $error("sync fault flag not cleared by read");
  AST_FAULT_SET: assert property (flagsRead0 && syncFaultIn[0] |=> flagArr[0].syncFault)
    else $error("sync fault lost when read in same cycle");
  AST_LOSS_LATCH: assert property (
    passLossHit[0] |=> flagArr[0].passLoss ##1 (flagArr[0].passLoss || $past(flagsRead0)))
    else $error("pass loss not latched");
  AST_FILTER_WRITE: assert property (
    hit(regReq, `ADDR_FILTER_RANGE, 1'b1)
    |=> filterUpperBound == $past(regReq.wdata[7:4]) && filterLowerBound == $past(regReq.wdata[3:0]))
    else $error("filter range not stored");
  AST_ENABLE_WRITE: assert property (
    hit(regReq, `ADDR_IRQ_ENABLE, 1'b1) && portSelReg == 1'b0
    |=> enableArr[0] == $past(regReq.wdata[4:0]))
    else $error("enable write missed selected port");
  AST_PASS_ALL: assert property (
    passAllMode && ((rxValid & g_port[0].mask) != g_port[0].mask)
    |=> !passLive[0])
    else $error("pass asserted with a port missing in all mode");

  // ---------------------------------------------------------------------------
  // Read path, port isolation and holding of state
  // ---------------------------------------------------------------------------
  // Read data shows the flags as they stood before the clear
  AST_FLAGS_READ: assert property (flagsRead0 |=> regRdata == {3'h0, $past(flagArr[0])})
    else $error("flag read returned wrong data");

  // Reserved upper bits of both interrupt registers read zero
  AST_RESERVED_ZERO: assert property (
    regReq.read && (regReq.addr == `ADDR_IRQ_ENABLE || regReq.addr == `ADDR_IRQ_FLAGS)
    |=> regRdata[7:5] == 3'h0)
    else $error("reserved bits not read as zero");

  // Any mode: one valid forwarded port is enough for pass
  AST_PASS_ANY: assert property (
    !passAllMode && |(rxValid & g_port[0].mask) |=> passLive[0])
    else $error("pass missing with a valid port in any mode");

  // Receive flag drops once no forwarded port has one pending
  AST_RX_DROP: assert property (!(|(rxIntPending & g_port[0].mask)) |=> !flagArr[0].rxEvent)
    else $error("receive flag kept without a source");

  // Latched flags stay until a read of this port's flags
  AST_PASS_HOLD: assert property (flagArr[0].passEvent && !flagsRead0 |=> flagArr[0].passEvent)
    else $error("pass flag lost without a read");
  AST_SYNC_HOLD: assert property (flagArr[0].synced && !flagsRead0 |=> flagArr[0].synced)
    else $error("synced flag lost without a read");
  AST_FAULT_HOLD: assert property (flagArr[0].syncFault && !flagsRead0 |=> flagArr[0].syncFault)
    else $error("sync fault flag lost without a read");

  // A read with no new loss in the same cycle clears the loss flag
  AST_LOSS_CLEAR: assert property (flagsRead0 && !passLossHit[0] |=> !flagArr[0].passLoss)
    else $error("pass loss flag not cleared by read");

  // Enables of port 0 change only on a write while port 0 is selected
  AST_ENABLE_HOLD: assert property (
    !(hit(regReq, `ADDR_IRQ_ENABLE, 1'b1) && portSelReg == 1'b0) |=> $stable(enableArr[0]))
    else $error("port 0 enables changed without a write to them");

  // Port select keeps bit 0 of the written byte
  AST_PORT_SELECT: assert property (
    hit(regReq, `ADDR_PORT_SELECT, 1'b1) |=> portSelect == $past(regReq.wdata[`PORT_SELECT_BIT]))
    else $error("port select not stored");

  // Filter bounds change only on a write to their register
  AST_FILTER_HOLD: assert property (
    !hit(regReq, `ADDR_FILTER_RANGE, 1'b1) |=> $stable(filterUpperBound) && $stable(filterLowerBound))
    else $error("filter range changed without a write");

  // The highest port combines its own flags and enables as well
  AST_IRQ_LAST: assert property (
    irqOut[NUM_TX_PORTS-1] == |(flagArr[NUM_TX_PORTS-1] & enableArr[NUM_TX_PORTS-1]))
    else $error("irq of highest port does not match flags and enables");

  // Main scenarios reached
  COV_PASS_IRQ: cover property (enableArr[0].passEvent && $rose(passLive[0]) ##1 irqOut[0]);
  COV_READ_CLEAR: cover property (flagArr[0].synced && flagsRead0 ##1 !flagArr[0].synced);
  COV_LOSS: cover property (passLossHit[0] ##1 flagArr[0].passLoss);
  COV_FAULT_IRQ: cover property (enableArr[0].syncFault && syncFaultIn[0] ##1 irqOut[0]);
  COV_HIGH_PORT_WRITE: cover property (portSelReg && hit(regReq, `ADDR_IRQ_ENABLE, 1'b1)
    ##1 enableArr[NUM_TX_PORTS-1] != '0);

endmodule // csi_tx_interrupt

`default_nettype wire

// [logic/csi_tx_irq_params.svh]
// Register offsets, field positions and reset values for the CSI-2 transmit
// interrupt block. Assumes an I2C slave in front that issues byte accesses.
`ifndef CSI_TX_IRQ_PARAMS_SVH
`define CSI_TX_IRQ_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define ADDR_PORT_SELECT  8'h32
`define ADDR_IRQ_ENABLE   8'h36
`define ADDR_IRQ_FLAGS    8'h37
`define ADDR_FILTER_RANGE 8'h41

// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define BIT_RX_EVENT      4
`define BIT_SYNC_FAULT    3
`define BIT_SYNCED        2
`define BIT_PASS_LOSS     1
`define BIT_PASS_EVENT    0
`define IRQ_FIELD_W       5
`define PORT_SELECT_BIT   0
`define FILTER_UPPER_LSB  4
`define FILTER_LOWER_LSB  0
`define RESET_IRQ_ENABLE  5'h00
`define RESET_IRQ_FLAGS   5'h00
`define RESET_FILTER      8'hA9
`define RESET_PORT_SELECT 1'h0

`endif

// [logic/csi_tx_irq_pkg.sv]
// Types shared by the CSI-2 transmit interrupt block.
// Assumes csi_tx_irq_params.svh is on the include path.
`default_nettype none
`include "csi_tx_irq_params.svh"

package csi_tx_irq_pkg;

  // Register access as handed over by the I2C slave, one-cycle strobes
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // One bit per interrupt source, in register bit order (4 down to 0)
  typedef struct packed {
    logic rxEvent;
    logic syncFault;
    logic synced;
    logic passLoss;
    logic passEvent;
  } irq_bits_t;

endpackage

`default_nettype wire

// [logic/tx_port_flags.sv]
// Enable and latched flag bank for one CSI-2 transmit port.
// Assumes event inputs are synchronous to sys_clk; strobes are one cycle.
`default_nettype none
`include "csi_tx_irq_params.svh"

module tx_port_flags
  import csi_tx_irq_pkg::*;
(
  input  wire logic      sys_clk,       // System clock
  input  wire logic      resetn,        // Async reset, active low
  input  wire logic      enableWrite,   // Write to enable register
  input  wire logic [4:0] writeData,    // Enable bits to store
  input  wire logic      flagsRead,     // Read of flag register
  input  wire logic      rxEventLevel,  // Forwarded receive interrupt pending
  input  wire logic      syncFaultHit,  // Sync error detected pulse
  input  wire logic      passLossHit,   // Forwarded port lost valid video
  input  wire logic      syncedRaw,     // Gated synchronized state
  input  wire logic      passRaw,       // Pass indication
  output var  irq_bits_t enableReg,     // Stored enables
  output var  irq_bits_t flagsReg,      // Latched flags
  output logic           irqReg,        // Combined interrupt request
  output logic           syncedLiveReg, // Live synchronized state
  output logic           passLiveReg    // Live pass state
);

  irq_bits_t enableNext;
  irq_bits_t flagsNext;
  logic      irqNext;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Sticky flags (all but rxEvent, which follows its level): a set in the read cycle wins over the clear
  always_comb begin
    enableNext = enableWrite ? irq_bits_t'(writeData) : enableReg;
    flagsNext.rxEvent   = rxEventLevel;
    flagsNext.syncFault = (flagsReg.syncFault & ~flagsRead) | syncFaultHit;
    flagsNext.synced    = (flagsReg.synced & ~flagsRead) | (syncedRaw & ~syncedLiveReg);
    flagsNext.passLoss  = (flagsReg.passLoss & ~flagsRead) | passLossHit;
    flagsNext.passEvent = (flagsReg.passEvent & ~flagsRead) | (passRaw & ~passLiveReg);
    irqNext = |(flagsNext & enableNext);
  end

  // Register stage
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      enableReg     <= irq_bits_t'(`RESET_IRQ_ENABLE);
      flagsReg      <= irq_bits_t'(`RESET_IRQ_FLAGS);
      irqReg        <= 1'b0;
      syncedLiveReg <= 1'b0;
      passLiveReg   <= 1'b0;
    end else begin
      enableReg     <= enableNext;
      flagsReg      <= flagsNext;
      irqReg        <= irqNext;
      syncedLiveReg <= syncedRaw;
      passLiveReg   <= passRaw;
    end
  end

endmodule // tx_port_flags

`default_nettype wire

// [tb/host_model.sv]
// Register host model: issues one-cycle read and write strobes.
// Assumes strobes change at the falling edge and are taken at the next rise.
`default_nettype none

module host_model
  import csi_tx_irq_pkg::*;
(
  input  wire logic       sys_clk,  // Block clock
  output var  reg_req_t   regReq,   // Register access strobe
  input  wire logic [7:0] regRdata  // Read data from block
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial regReq = '0;

  // Write one byte; released fields show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regReq = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    regReq = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // Read one byte; data held until next read, sampled a cycle late
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regReq = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    regReq = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hFF};
    @(negedge sys_clk);
    d = regRdata;
  endtask

  // Filter bounds are only written in legal order and range
  task automatic wrFilter(input logic [3:0] hi, input logic [3:0] lo);
    if (hi >= lo && hi <= 4'hE) wr(8'h41, {hi, lo});
  endtask
endmodule // host_model

`default_nettype wire

// [tb/test_csi_tx_interrupt.sv]
// Self-checking bench for the transmit interrupt and filter range block.
// Assumes host_model drives the register strobes; events driven at falling edge.
`default_nettype none

module test_csi_tx_interrupt
  import csi_tx_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk = 1'b0;
  logic       resetn  = 1'b0;
  reg_req_t   regReq;
  logic [7:0] regRdata, d;
  logic [3:0] rxValid = 4'h0, rxIntPending = 4'h0;
  logic [7:0] forwardMask = 8'h03;
  logic       passAllMode = 1'b0, syncForwardEn = 1'b0;
  logic [1:0] syncedIn = 2'h0, syncFaultIn = 2'h0;
  logic [1:0] irqOut, passLive, syncedLive;
  logic [3:0] filterUpperBound, filterLowerBound;
  logic       portSelect;
  int         error_cnt = 0, comparisons = 0;

  always #5 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .regReq(regReq), .regRdata(regRdata));

  csi_tx_interrupt #(.NUM_TX_PORTS(2), .NUM_RX_PORTS(4)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .regReq(regReq), .regRdata(regRdata),
    .rxValid(rxValid), .rxIntPending(rxIntPending), .forwardMask(forwardMask),
    .passAllMode(passAllMode), .syncForwardEn(syncForwardEn), .syncedIn(syncedIn),
    .syncFaultIn(syncFaultIn), .irqOut(irqOut), .passLive(passLive), .syncedLive(syncedLive),
    .filterUpperBound(filterUpperBound), .filterLowerBound(filterLowerBound),
    .portSelect(portSelect));

  // ---------------------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    host.rd(a, d);
    chk(nm, exp, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic testReset();
    chk("upper", 8'h0A, {4'h0, filterUpperBound});
    rdChk(8'h41, 8'hA9, "filter");
    rdChk(8'h36, 8'h00, "enable");
    rdChk(8'h37, 8'h00, "flags");
    rdChk(8'h50, 8'h00, "unmapped");
    host.wr(8'h36, 8'hFF);
    host.wr(8'h37, 8'hFF);
    rdChk(8'h36, 8'h1F, "enable reserved");
    rdChk(8'h37, 8'h00, "flags readonly");
    $display("reset and access test done");
  endtask

  task automatic testPass();
    host.wr(8'h36, 8'h02);
    rxValid = 4'h1;
    tick(2);
    chk("passLive", 8'h01, {7'h00, passLive[0]});
    chk("irq masked", 8'h00, {7'h00, irqOut[0]});
    rdChk(8'h37, 8'h01, "pass flag");
    rdChk(8'h37, 8'h00, "pass cleared");
    rxValid = 4'h0;
    tick(2);
    chk("irq loss", 8'h01, {7'h00, irqOut[0]});
    rdChk(8'h37, 8'h02, "loss flag");
    host.wr(8'h36, 8'h01);
    passAllMode = 1'b1;
    rxValid = 4'h1;
    rdChk(8'h37, 8'h00, "all mode one");
    rxValid = 4'h3;
    tick(2);
    chk("irq pass", 8'h01, {7'h00, irqOut[0]});
    rdChk(8'h37, 8'h01, "all mode both");
    chk("irq cleared", 8'h00, {7'h00, irqOut[0]});
    passAllMode = 1'b0;
    rxValid = 4'h0;
    rdChk(8'h37, 8'h02, "loss again");
    $display("pass test done");
  endtask

  task automatic testSync();
    host.wr(8'h36, 8'h04);
    syncedIn = 2'h1;
    tick(2);
    chk("syncedLive off", 8'h00, {7'h00, syncedLive[0]});
    rdChk(8'h37, 8'h00, "no synced");
    syncForwardEn = 1'b1;
    tick(2);
    chk("irq synced", 8'h01, {7'h00, irqOut[0]});
    chk("syncedLive on", 8'h01, {7'h00, syncedLive[0]});
    rdChk(8'h37, 8'h04, "synced flag");
    host.wr(8'h36, 8'h08);
    syncFaultIn = 2'h1;
    tick(1);
    syncFaultIn = 2'h0;
    tick(1);
    chk("irq fault", 8'h01, {7'h00, irqOut[0]});
    rdChk(8'h37, 8'h08, "fault flag");
    rdChk(8'h37, 8'h00, "fault cleared");
    syncedIn = 2'h0;
    $display("sync test done");
  endtask

  task automatic testRxEvent();
    host.wr(8'h36, 8'h10);
    rxIntPending = 4'h2;
    tick(2);
    chk("irq rx", 8'h01, {7'h00, irqOut[0]});
    rdChk(8'h37, 8'h10, "rx flag");
    rdChk(8'h37, 8'h10, "rx kept");
    rxIntPending = 4'h0;
    rdChk(8'h37, 8'h00, "rx gone");
    $display("receive event test done");
  endtask

  task automatic testPortAndFilter();
    host.wr(8'h32, 8'h01);
    rdChk(8'h32, 8'h01, "port select");
    rdChk(8'h36, 8'h00, "port1 enable");
    host.wr(8'h36, 8'h03);
    host.wr(8'h32, 8'h00);
    rdChk(8'h36, 8'h10, "port0 enable");
    host.wrFilter(4'hE, 4'h0);
    rdChk(8'h41, 8'hE0, "filter");
    chk("lower", 8'h00, {4'h0, filterLowerBound});
    chk("upper", 8'h0E, {4'h0, filterUpperBound});
    $display("port and filter test done");
  endtask

  // Receive port 2 forwarded to transmit port 1 only; port 0 has an empty mask
  task automatic testPortIsolation();
    forwardMask = 8'h40;
    host.wr(8'h32, 8'h01);
    chk("portSelect", 8'h01, {7'h00, portSelect});
    rxValid = 4'h4;
    tick(2);
    chk("irq port1", 8'h01, {7'h00, irqOut[1]});
    chk("irq port0", 8'h00, {7'h00, irqOut[0]});
    rdChk(8'h37, 8'h01, "port1 pass");
    host.wr(8'h32, 8'h00);
    chk("portSelect back", 8'h00, {7'h00, portSelect});
    rdChk(8'h37, 8'h00, "port0 quiet");
    passAllMode = 1'b1;
    tick(2);
    chk("all mode empty mask", 8'h00, {7'h00, passLive[0]});
    chk("all mode port1", 8'h01, {7'h00, passLive[1]});
    rxValid = 4'h0;
    tick(2);
    chk("irq port1 loss", 8'h01, {7'h00, irqOut[1]});
    passAllMode = 1'b0;
    $display("port isolation test done");
  endtask

  // Watchdog cuts a hang short
  initial begin
    tick(5000);
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    tick(6);
    resetn = 1'b1;
    testReset();
    testPass();
    testSync();
    testRxEvent();
    testPortAndFilter();
    testPortIsolation();
    complete_run();
  end
endmodule // test_csi_tx_interrupt

`default_nettype wire
